// file: rtl/ueirq_pkg.sv
// Package with register map, field layout and reset values of the endpoint interrupt block
// What this block does
// R1: Tx status bits 3:0, endpoint 0 plus tx 1-3
// R2: Rx status bits 3:1, bit 0 reads zero
// R3: Unconfigured endpoint status bits clear one cycle after the config register changes
// R4: Reading a status register clears its flags
// R5: Enabled set status bit raises the interrupt
// R6: Disabled bits still latch, no interrupt
// R7: Tx enable resets to 0x000F, bits 15:4 zero
// R8: Rx enable resets to 0x000E, bit 0 zero
// R9: Both status registers reset to zero
// R10: Software preserves reserved bits on rewrite
// R11: Interrupt is OR of status AND enable
// R12: Event during clearing read stays latched
package ueirq_pkg;
  localparam int          UEIRQ_ADDR_W       = 4;
  localparam int          UEIRQ_DATA_W       = 16;
  localparam int          UEIRQ_EP_W         = 4;
  // Printed register offsets
  localparam logic [3:0]  UEIRQ_TX_STATUS    = 4'h2;
  localparam logic [3:0]  UEIRQ_RX_STATUS    = 4'h4;
  localparam logic [3:0]  UEIRQ_TX_ENABLE    = 4'h6;
  localparam logic [3:0]  UEIRQ_RX_ENABLE    = 4'h8;
  // Own registers: endpoint configuration and interrupt summary
  localparam logic [3:0]  UEIRQ_EP_CONFIG    = 4'hC;
  localparam logic [3:0]  UEIRQ_IRQ_SUMMARY  = 4'hE;
  // Field layout: implemented bits per register
  localparam logic [3:0]  UEIRQ_TX_MASK      = 4'hF;
  localparam logic [3:0]  UEIRQ_RX_MASK      = 4'hE;
  // Reset values
  localparam logic [3:0]  UEIRQ_STATUS_RST   = 4'h0;
  localparam logic [3:0]  UEIRQ_TX_EN_RST    = 4'hF;
  localparam logic [3:0]  UEIRQ_RX_EN_RST    = 4'hE;
  localparam logic [3:0]  UEIRQ_CONFIG_RST   = 4'hF;
endpackage : ueirq_pkg

// file: rtl/ueirq_flags.sv
// Sticky read-to-clear flag group with configuration gating
`timescale 1ns/1ps
module ueirq_flags #(
  parameter logic [3:0] IMPL_MASK = 4'hF
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // Events and control
  input  wire logic [3:0] event_pulse,
  input  wire logic [3:0] ep_configured,
  input  wire logic       clear_rd,
  // Flag state
  output logic      [3:0] flags_reg
);
  import ueirq_pkg::*;

  logic [3:0] flags_next;
  logic [3:0] gate;

  // Only implemented and configured endpoints may hold a flag
  assign gate = IMPL_MASK & ep_configured; // R3

  // Set wins over the read clear so no event is lost
  always_comb begin
    flags_next = clear_rd ? 4'h0 : flags_reg; // R4
    flags_next = (flags_next | event_pulse) & gate; // R12 R6
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_reg <= UEIRQ_STATUS_RST; // R9
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule : ueirq_flags

// file: rtl/ueirq_top.sv
// Endpoint interrupt status and enable registers with one processor interrupt
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module ueirq_top (
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           sys_rst,
  // Endpoint events, one-cycle pulses from transfer logic
  input  wire logic [ueirq_pkg::UEIRQ_EP_W-1:0] tx_event,
  input  wire logic [ueirq_pkg::UEIRQ_EP_W-1:0] rx_event,
  // Register port
  input  wire logic [ueirq_pkg::UEIRQ_ADDR_W-1:0] reg_addr,
  input  wire logic [ueirq_pkg::UEIRQ_DATA_W-1:0] reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [ueirq_pkg::UEIRQ_DATA_W-1:0] reg_rdata,
  // Processor interrupt
  output logic                                irq_out
);
  import ueirq_pkg::*;

  logic [3:0]  tx_enable_reg;
  logic [3:0]  rx_enable_reg;
  logic [3:0]  ep_config_reg;
  logic [3:0]  tx_flags;
  logic [3:0]  rx_flags;
  logic        rd_tx;
  logic        rd_rx;
  logic [15:0] rdata_next;
  logic        irq_next;

  // Widen a four-bit field into the low bits of a data word
  function automatic logic [15:0] widen(input logic [3:0] v);
    widen = {12'h000, v};
  endfunction : widen

  assign rd_tx = reg_rd && (reg_addr == UEIRQ_TX_STATUS);
  assign rd_rx = reg_rd && (reg_addr == UEIRQ_RX_STATUS);

  // Tx group: endpoint 0 and tx endpoints 1 to 3
  ueirq_flags #(.IMPL_MASK(UEIRQ_TX_MASK)) u_tx_flags ( // R1
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .event_pulse   (tx_event),
    .ep_configured (ep_config_reg),
    .clear_rd      (rd_tx),
    .flags_reg     (tx_flags)
  );

  // Rx group: bit 0 is not implemented
  ueirq_flags #(.IMPL_MASK(UEIRQ_RX_MASK)) u_rx_flags ( // R2
    .core_clk      (core_clk),
    .sys_rst       (sys_rst),
    .event_pulse   (rx_event),
    .ep_configured (ep_config_reg),
    .clear_rd      (rd_rx),
    .flags_reg     (rx_flags)
  );

  // Enable registers; reserved bits are never stored
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_enable_reg <= UEIRQ_TX_EN_RST; // R7
      rx_enable_reg <= UEIRQ_RX_EN_RST; // R8
    end else if (reg_wr) begin
      if (reg_addr == UEIRQ_TX_ENABLE) begin
        tx_enable_reg <= reg_wdata[3:0] & UEIRQ_TX_MASK; // R7
      end
      if (reg_addr == UEIRQ_RX_ENABLE) begin
        rx_enable_reg <= reg_wdata[3:0] & UEIRQ_RX_MASK; // R8
      end
    end
  end

  // Endpoint configuration; bit n marks endpoint n as configured
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ep_config_reg <= UEIRQ_CONFIG_RST;
    end else if (reg_wr && (reg_addr == UEIRQ_EP_CONFIG)) begin
      ep_config_reg <= reg_wdata[3:0];
    end
  end

  // Read mux; status is sampled before the clear takes effect
  always_comb begin
    case (reg_addr)
      UEIRQ_TX_STATUS:   rdata_next = widen(tx_flags); // R4
      UEIRQ_RX_STATUS:   rdata_next = widen(rx_flags); // R4
      UEIRQ_TX_ENABLE:   rdata_next = widen(tx_enable_reg);
      UEIRQ_RX_ENABLE:   rdata_next = widen(rx_enable_reg);
      UEIRQ_EP_CONFIG:   rdata_next = widen(ep_config_reg);
      UEIRQ_IRQ_SUMMARY: rdata_next = {14'h0000, |(rx_flags & rx_enable_reg),
                                       |(tx_flags & tx_enable_reg)};
      default:           rdata_next = 16'h0000; // Unmapped reads as zero
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 16'h0000;
    end
  end

  // Interrupt from registered flag state puts it two registers away from the event
  assign irq_next = |(tx_flags & tx_enable_reg) | |(rx_flags & rx_enable_reg); // R11 R5 R6

  // Registered for a clean output; adds one cycle of latency
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_next; // R11
    end
  end
endmodule : ueirq_top

// file: tb/ueirq_sva.sv
// Port checker for the endpoint interrupt block
`timescale 1ns/1ps
module ueirq_sva (
  // Clock
  input logic        core_clk,
  input logic        sys_rst,
  // Watched
  input logic [3:0]  tx_event,
  input logic [3:0]  rx_event,
  input logic [3:0]  reg_addr,
  input logic        reg_wr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  input logic        irq_out
);
  // One domain, reset quiets all checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Read of tx status
  wire rd_tx = reg_rd && reg_addr == 4'h2;
  a_rdata_idle: assert property (!reg_rd |=> !reg_rdata) else $error("idle");
  a_upper_zero: assert property (reg_rdata[15:4] == 0) else $error("upper");
  a_rx_bit0: assert property (reg_rd && reg_addr == 4 |=> !reg_rdata[0]) else $error("rx0");
  a_rxen_bit0: assert property (reg_rd && reg_addr == 8 |=> !reg_rdata[0]) else $error("en0");
  a_read_clear: assert property (rd_tx && !tx_event ##1 rd_tx |=> !reg_rdata) else $error("clr");
  a_event_kept: assert property (rd_tx && tx_event[1] ##1 rd_tx |=> reg_rdata[1]) else $error("kept");
  // A rise needs an event or enable write two cycles back
  a_irq_rise: assert property ($rose(irq_out) |-> $past(|{tx_event, rx_event, reg_wr}, 2))
    else $error("rise");
  a_irq_fall: assert property ($fell(irq_out) |-> $past(reg_rd || reg_wr, 2)) else $error("fall");
  c_rise: cover property ($rose(irq_out));
  c_fall: cover property ($fell(irq_out));
  c_kept: cover property (rd_tx && tx_event[1] ##1 rd_tx);
endmodule : ueirq_sva
bind ueirq_top ueirq_sva ueirq_sva_i (.core_clk(core_clk), .sys_rst(sys_rst),
  .tx_event(tx_event), .rx_event(rx_event), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out));

// file: tb/tb_ueirq_top.sv
// Random register and event traffic checked against a cycle model
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_ueirq_top;
  logic        core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, irq_out, q1 = 0, q2 = 0, prd = 0;
  logic [3:0]  tx_event = 0, rx_event = 0, reg_addr = 0, a, te, re, m [16];
  logic [15:0] reg_wdata = 0, reg_rdata, ex, pe;
  logic [31:0] t;
  int          n_mismatch = 0, tests_run = 0, k, op;
  ueirq_top ueirq_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .tx_event(tx_event),
    .rx_event(rx_event), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out));
  // 50 ns clock
  initial forever #25 core_clk = ~core_clk;
  // Verdict
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // One bus cycle driven after the rising edge, then wait for the settled half
  task automatic step(input logic rd, input logic wr, input logic [3:0] ad,
                      input logic [15:0] wd, input logic [3:0] tv, input logic [3:0] rv);
    @(posedge core_clk);
    reg_rd    <= rd;
    reg_wr    <= wr;
    reg_addr  <= ad;
    reg_wdata <= wd;
    tx_event  <= tv;
    rx_event  <= rv;
    @(negedge core_clk);
  endtask : step
  // Back-to-back operations; the first ten read 0 to 9 for reset values
  initial begin
    m = '{6: 4'hF, 8: 4'hE, default: 4'h0};
    void'($urandom(16));
    repeat (12) @(posedge core_clk);
    sys_rst <= 0;
    for (k = 0; k < 3000; k++) begin
      t = $urandom;
      op = k < 10 ? 1 : t[9:8] % 3;
      a = k < 10 ? 4'(k) : 4'(2 * t[5:4] + 2);
      te = k < 10 ? 4'h0 : t[3:0] & t[13:10];
      re = k < 10 ? 4'h0 : t[7:4] & t[17:14];
      ex = {12'h000, m[a]};
      @(posedge core_clk);
      reg_rd <= op == 1;
      reg_wr <= op == 2;
      reg_addr <= a;
      reg_wdata <= {12'h000, t[19:16] & (a == 8 ? 4'hE : 4'hF)};
      tx_event <= te;
      rx_event <= re;
      // Sample between edges, where all outputs have settled
      @(negedge core_clk);
      `CHK("rdata", prd ? pe : 16'h0000, reg_rdata)
      `CHK("irq", q2, irq_out)
      {pe, prd, q2} = {ex, op == 1, q1};
      if (op == 1 && a < 5) m[a] = 4'h0;
      if (op == 2 && a > 5) m[a] = t[19:16] & (a == 8 ? 4'hE : 4'hF);
      m[2] |= te;
      m[4] |= re & 4'hE;
      q1 = |{m[2] & m[6], m[4] & m[8]};
    end
    // Corner: only endpoints 0 and 2 configured, every event fires at once
    step(1'b0, 1'b1, 4'hC, 16'h0005, 4'h0, 4'h0);
    step(1'b0, 1'b0, 4'h0, 16'h0000, 4'hF, 4'hF);
    step(1'b1, 1'b0, 4'hE, 16'h0000, 4'h0, 4'h0);
    step(1'b1, 1'b0, 4'h2, 16'h0000, 4'h0, 4'h0);
    `CHK("summary", {14'h0000, |(4'h4 & m[8]), |(4'h5 & m[6])}, reg_rdata)
    step(1'b1, 1'b0, 4'h4, 16'h0000, 4'h0, 4'h0);
    `CHK("tx_unconf", 16'h0005, reg_rdata)
    step(1'b0, 1'b1, 4'hC, 16'h000F, 4'h0, 4'h0);
    `CHK("rx_unconf", 16'h0004, reg_rdata)
    step(1'b0, 1'b0, 4'h0, 16'h0000, 4'h0, 4'h0);
    close_out();
  end
endmodule : tb_ueirq_top
